// [cafb_pkg.sv]
// Shared constants and types for the CAN acceptance filter and buffering.
// Assumes one clock domain; center numbers are 0-based indices (0 = center 1).
package cafb_pkg;
   localparam int NUM_CENTERS     = 15;
   localparam int ID_W            = 29;
   localparam int STD_ID_W        = 11;
   localparam int DATA_W          = 64;
   localparam int MEDIA_W         = 16;
   localparam int FMT_W           = 8;
   localparam int IDX_W           = 4;
   localparam int ERR_W           = 8;
   localparam int MAX_DATA_BYTES  = 8;
   // Index of the special receive-only center
   localparam logic [3:0] LAST_IDX = 4'hE;
   // Center format field positions
   localparam int FMT_MEDIA_BIT   = 0;
   localparam int FMT_MASK_BIT    = 1;
   localparam int FMT_EXT_BIT     = 2;
   localparam int FMT_DIR_BIT     = 3;
   localparam int FMT_LEN_LSB     = 4;
   localparam int FMT_LEN_W       = 4;
   // Error count limits and status bit
   localparam logic [7:0] ERR_LIMIT_LO = 8'h60;
   localparam logic [7:0] ERR_LIMIT_HI = 8'h80;
   localparam int STAT_EXCEEDED_BIT    = 6;
   // Bus timing register fields
   localparam int T0_PRESC_LSB    = 0;
   localparam int T0_PRESC_W      = 6;
   localparam int T1_TIME_SEGMENT_ONE_LSB    = 0;
   localparam int T1_TIME_SEGMENT_ONE_W      = 4;
   localparam int T1_TIME_SEGMENT_TWO_LSB    = 4;
   localparam int T1_TIME_SEGMENT_TWO_W      = 3;
   localparam logic [7:0] TIMING_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SCAN  = 3'b010,
      ST_STORE = 3'b100
   } cafb_state_t;
endpackage : cafb_pkg

// [cafb_match_if.sv]
// Bundle between the scan controller and the identifier filter.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface cafb_match_if;
   logic [28:0] id;
   logic        frame_ext;
   logic [15:0] media_bytes;
   logic [28:0] arb;
   logic [7:0]  fmt;
   logic        is_last;
   logic        hit;
   modport ctrl (output id, frame_ext, media_bytes, arb, fmt, is_last,
                 input hit);
   modport filt (input id, frame_ext, media_bytes, arb, fmt, is_last,
                 output hit);
endinterface : cafb_match_if

// [cafb_filter.sv]
// Combinational acceptance test of one frame against one center.
// Assumes masks are held steady by the caller during a scan.
`timescale 1ns/1ps
module cafb_filter (
   // Test operands and result
   cafb_match_if.filt           m,
   // Masks
   input  wire logic [10:0]     std_mask_in,
   input  wire logic [28:0]     ext_mask_in,
   input  wire logic [10:0]     last_std_mask_in,
   input  wire logic [28:0]     last_ext_mask_in,
   input  wire logic [15:0]     media_mask_in,
   input  wire logic [15:0]     media_arb_in
);
   logic [10:0] std_eff;
   logic [28:0] ext_eff;
   logic        id_ok;
   logic        media_ok;
   logic        ext_sel;

   always_comb begin
      ext_sel = m.fmt[cafb_pkg::FMT_EXT_BIT];
      std_eff = 11'h7FF;
      ext_eff = 29'h1FFFFFFF;
      if (m.fmt[cafb_pkg::FMT_MASK_BIT]) begin
         std_eff = std_mask_in;
         ext_eff = ext_mask_in;
         if (m.is_last) begin
            std_eff = std_mask_in & last_std_mask_in;
            ext_eff = ext_mask_in & last_ext_mask_in;
         end
      end
      // Width of compare follows the center format
      if (ext_sel)
         id_ok = (((m.id ^ m.arb) & ext_eff) == 29'h0);
      else
         id_ok = (((m.id[10:0] ^ m.arb[10:0]) & std_eff) == 11'h0);
      id_ok = id_ok && (m.frame_ext == ext_sel);
      media_ok = !m.fmt[cafb_pkg::FMT_MEDIA_BIT] ||
         (((m.media_bytes ^ media_arb_in) & media_mask_in) == 16'h0);
   end

   assign m.hit = id_ok && media_ok;
endmodule : cafb_filter

// [cafb_top.sv]
// Receive acceptance scan, center storage, overwrite handling, center-15
// double buffer, transmit reload pick, error limit alert, timing reload.
// Assumes frames arrive error-free as one-cycle strobes, spaced by at
// least 17 cycles, and all inputs synchronous to CLK_IN.
`timescale 1ns/1ps
module cafb_top (
   // Clock and reset
   input  wire logic          CLK_IN,
   input  wire logic          ARST_N_IN,
   // Received frame
   input  wire logic          FRAME_VALID_IN,
   input  wire logic [28:0]   FRAME_ID_IN,
   input  wire logic          FRAME_EXT_IN,
   input  wire logic          FRAME_RTR_IN,
   input  wire logic [63:0]   FRAME_DATA_IN,
   // Masks and media arbitration
   input  wire logic [10:0]   STD_MASK_IN,
   input  wire logic [28:0]   EXT_MASK_IN,
   input  wire logic [10:0]   LAST_STD_MASK_IN,
   input  wire logic [28:0]   LAST_EXT_MASK_IN,
   input  wire logic [15:0]   MEDIA_MASK_IN,
   input  wire logic [15:0]   MEDIA_ARB_IN,
   // Per-center configuration
   input  wire logic [14:0]   CENTER_ENABLED_IN,
   input  wire logic [434:0]  CENTER_ARB_IN,
   input  wire logic [119:0]  CENTER_FORMAT_IN,
   input  wire logic [14:0]   OVERWRITE_ENABLE_IN,
   // Software flag clears
   input  wire logic [14:0]   CLEAR_UPDATED_IN,
   input  wire logic [14:0]   CLEAR_IRQ_IN,
   input  wire logic [14:0]   CLEAR_REMOTE_IN,
   input  wire logic [14:0]   CLEAR_OVERWRITE_IN,
   // Center flags
   output logic      [14:0]   DATA_UPDATED_OUT,
   output logic      [14:0]   CENTER_IRQ_OUT,
   output logic      [14:0]   REMOTE_REQ_OUT,
   output logic      [14:0]   OVERWRITE_FLAG_OUT,
   // Center read port
   input  wire logic [3:0]    READ_INDEX_IN,
   output logic      [63:0]   READ_DATA_OUT,
   output logic      [28:0]   READ_ID_OUT,
   // Transmit side
   input  wire logic          TX_DONE_IN,
   input  wire logic [3:0]    TX_DONE_INDEX_IN,
   input  wire logic [14:0]   TX_PENDING_IN,
   input  wire logic          TX_RELOAD_IN,
   output logic               TX_LOAD_VALID_OUT,
   output logic      [3:0]    TX_LOAD_INDEX_OUT,
   // Error counters and interrupt
   input  wire logic [7:0]    TX_ERR_COUNT_IN,
   input  wire logic [7:0]    RX_ERR_COUNT_IN,
   input  wire logic          ERROR_LIMIT_SELECT_IN,
   input  wire logic          ERROR_IRQ_ENABLE_IN,
   input  wire logic          CAN_IRQ_ENABLE_IN,
   input  wire logic          GLOBAL_IRQ_ENABLE_IN,
   output logic      [7:0]    STATUS_OUT,
   output logic               ERROR_IRQ_OUT,
   // Bus timing
   input  wire logic [7:0]    TIMING_ZERO_IN,
   input  wire logic [7:0]    TIMING_ONE_IN,
   input  wire logic          SOFTWARE_INITIALIZE_IN,
   output logic      [7:0]    ENGINE_TIMING_ZERO_OUT,
   output logic      [7:0]    ENGINE_TIMING_ONE_OUT,
   output logic      [5:0]    BAUD_PRESCALER_OUT,
   output logic               TIMING_LOAD_OUT
);
   cafb_pkg::cafb_state_t state;
   logic [3:0]   scan_idx;
   logic [28:0]  f_id;
   logic         f_ext;
   logic         f_rtr;
   logic [63:0]  f_data;
   logic [63:0]  mem_data [15];
   logic [28:0]  mem_id   [15];
   logic [63:0]  buf_data;
   logic [28:0]  buf_id;
   logic         buf_rtr;
   logic         buf_full;
   logic         eligible;
   logic         mem_we;
   logic         buf_we;
   logic         ovr_set;
   logic         move;
   logic [7:0]   cur_fmt;
   logic [7:0]   limit;
   logic         next_exceeded;
   logic         exceeded;
   logic         irq_en_all;
   logic         init_q;
   logic [14:0]  next_upd;
   logic [14:0]  next_irq;
   logic [14:0]  next_rem;

   cafb_match_if m ();

   // One-hot select of a center index
   function automatic logic [14:0] sel15(input logic [3:0] idx);
      sel15 = 15'h0000;
      if (idx < 4'hF)
         sel15[idx] = 1'b1;
   endfunction : sel15

   // Zero data bytes past the center's configured length
   function automatic logic [63:0] len_mask(input logic [3:0] len);
      len_mask = 64'h0;
      for (int b = 0; b < cafb_pkg::MAX_DATA_BYTES; b++)
         if (b < int'(len))
            len_mask[b*8 +: 8] = 8'hFF;
   endfunction : len_mask

   // Lowest pending transmit center, center 15 never included
   function automatic logic [4:0] tx_pick(input logic [14:0] ready);
      tx_pick = 5'h00;
      for (int i = cafb_pkg::NUM_CENTERS - 2; i >= 0; i--)
         if (ready[i])
            tx_pick = {1'b1, 4'(i)};
   endfunction : tx_pick

   assign cur_fmt     = CENTER_FORMAT_IN[scan_idx*8 +: 8];
   assign m.id        = f_id;
   assign m.frame_ext = f_ext;
   assign m.media_bytes = f_data[15:0];
   assign m.arb       = CENTER_ARB_IN[scan_idx*29 +: 29];
   assign m.fmt       = cur_fmt;
   assign m.is_last   = (scan_idx == cafb_pkg::LAST_IDX);

   cafb_filter u_filter (
      .m                (m),
      .std_mask_in      (STD_MASK_IN),
      .ext_mask_in      (EXT_MASK_IN),
      .last_std_mask_in (LAST_STD_MASK_IN),
      .last_ext_mask_in (LAST_EXT_MASK_IN),
      .media_mask_in    (MEDIA_MASK_IN),
      .media_arb_in     (MEDIA_ARB_IN)
   );

   // Receive centers only; the last center is always receive
   assign eligible = CENTER_ENABLED_IN[scan_idx] &&
      (m.is_last || !cur_fmt[cafb_pkg::FMT_DIR_BIT]);

   // Scan sequencer
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state    <= cafb_pkg::ST_IDLE;
         scan_idx <= 4'h0;
      end else begin
         case (state)
            cafb_pkg::ST_IDLE: begin
               if (FRAME_VALID_IN) begin
                  state    <= cafb_pkg::ST_SCAN;
                  scan_idx <= 4'h0;
               end
            end
            cafb_pkg::ST_SCAN: begin
               if (eligible && m.hit)
                  state <= cafb_pkg::ST_STORE;
               else if (m.is_last)
                  state <= cafb_pkg::ST_IDLE;
               else
                  scan_idx <= scan_idx + 4'h1;
            end
            cafb_pkg::ST_STORE:
               state <= cafb_pkg::ST_IDLE;
            default:
               state <= cafb_pkg::ST_IDLE;
         endcase
      end
   end

   // Frame capture
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         f_id   <= 29'h0;
         f_ext  <= 1'b0;
         f_rtr  <= 1'b0;
         f_data <= 64'h0;
      end else if (state == cafb_pkg::ST_IDLE && FRAME_VALID_IN) begin
         f_id   <= FRAME_ID_IN;
         f_ext  <= FRAME_EXT_IN;
         f_rtr  <= FRAME_RTR_IN;
         f_data <= FRAME_DATA_IN;
      end
   end

   // Disposition of an accepted frame
   always_comb begin
      mem_we  = 1'b0;
      buf_we  = 1'b0;
      ovr_set = 1'b0;
      move = buf_full && !DATA_UPDATED_OUT[14] && !CENTER_IRQ_OUT[14] &&
         !REMOTE_REQ_OUT[14];
      if (state == cafb_pkg::ST_STORE) begin
         if (scan_idx != cafb_pkg::LAST_IDX) begin
            if (!DATA_UPDATED_OUT[scan_idx])
               mem_we = 1'b1;
            else if (OVERWRITE_ENABLE_IN[scan_idx]) begin
               mem_we  = 1'b1;
               ovr_set = 1'b1;
            end
         end else begin
            move = 1'b0;
            // A waiting buffered frame keeps its place ahead of this one
            if (!DATA_UPDATED_OUT[14] && !buf_full)
               mem_we = 1'b1;
            else if (!buf_full)
               buf_we = 1'b1;
            else if (OVERWRITE_ENABLE_IN[14])
               buf_we = 1'b1;
         end
      end
   end

   // Center storage and the center-15 buffer
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (int i = 0; i < cafb_pkg::NUM_CENTERS; i++) begin
            mem_data[i] <= 64'h0;
            mem_id[i]   <= 29'h0;
         end
         buf_data <= 64'h0;
         buf_id   <= 29'h0;
         buf_rtr  <= 1'b0;
         buf_full <= 1'b0;
      end else begin
         if (mem_we) begin
            mem_data[scan_idx] <= f_data &
               len_mask(cur_fmt[cafb_pkg::FMT_LEN_LSB +: 4]);
            mem_id[scan_idx] <= f_id;
         end
         if (buf_we) begin
            buf_data <= f_data &
               len_mask(cur_fmt[cafb_pkg::FMT_LEN_LSB +: 4]);
            buf_id   <= f_id;
            buf_rtr  <= f_rtr;
            buf_full <= 1'b1;
         end else if (move) begin
            mem_data[14] <= buf_data;
            mem_id[14]   <= buf_id;
            buf_full     <= 1'b0;
         end
      end
   end

   // Center flags; a set in the same cycle beats a software clear
   always_comb begin
      next_upd = DATA_UPDATED_OUT & ~CLEAR_UPDATED_IN;
      next_irq = CENTER_IRQ_OUT & ~CLEAR_IRQ_IN;
      next_rem = REMOTE_REQ_OUT & ~CLEAR_REMOTE_IN;
      if (mem_we) begin
         next_upd = next_upd | sel15(scan_idx);
         next_irq = next_irq | sel15(scan_idx);
         if (f_rtr)
            next_rem = next_rem | sel15(scan_idx);
      end
      if (move) begin
         next_upd = next_upd | sel15(cafb_pkg::LAST_IDX);
         next_irq = next_irq | sel15(cafb_pkg::LAST_IDX);
         if (buf_rtr)
            next_rem = next_rem | sel15(cafb_pkg::LAST_IDX);
      end
      if (TX_DONE_IN && TX_DONE_INDEX_IN != cafb_pkg::LAST_IDX)
         next_irq = next_irq | sel15(TX_DONE_INDEX_IN);
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         DATA_UPDATED_OUT   <= 15'h0000;
         CENTER_IRQ_OUT     <= 15'h0000;
         REMOTE_REQ_OUT     <= 15'h0000;
         OVERWRITE_FLAG_OUT <= 15'h0000;
      end else begin
         DATA_UPDATED_OUT <= next_upd;
         CENTER_IRQ_OUT   <= next_irq;
         REMOTE_REQ_OUT   <= next_rem;
         OVERWRITE_FLAG_OUT <= (OVERWRITE_FLAG_OUT & ~CLEAR_OVERWRITE_IN) |
            (ovr_set ? sel15(scan_idx) : 15'h0000);
      end
   end

   // Read port
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         READ_DATA_OUT <= 64'h0;
         READ_ID_OUT   <= 29'h0;
      end else if (READ_INDEX_IN < 4'hF) begin
         READ_DATA_OUT <= mem_data[READ_INDEX_IN];
         READ_ID_OUT   <= mem_id[READ_INDEX_IN];
      end else begin
         READ_DATA_OUT <= 64'h0;
         READ_ID_OUT   <= 29'h0;
      end
   end

   // Transmit buffer reload after lost arbitration or error
   logic [14:0] tx_ready;
   logic [4:0]  tx_sel;
   always_comb begin
      tx_ready = 15'h0000;
      for (int i = 0; i < cafb_pkg::NUM_CENTERS; i++)
         tx_ready[i] = CENTER_ENABLED_IN[i] && TX_PENDING_IN[i] &&
            CENTER_FORMAT_IN[i*8 + cafb_pkg::FMT_DIR_BIT];
      tx_sel = tx_pick(tx_ready);
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         TX_LOAD_VALID_OUT <= 1'b0;
         TX_LOAD_INDEX_OUT <= 4'h0;
      end else begin
         TX_LOAD_VALID_OUT <= TX_RELOAD_IN && tx_sel[4];
         if (TX_RELOAD_IN && tx_sel[4])
            TX_LOAD_INDEX_OUT <= tx_sel[3:0];
      end
   end

   // Error count limit and interrupt
   assign limit = ERROR_LIMIT_SELECT_IN ? cafb_pkg::ERR_LIMIT_HI
                                        : cafb_pkg::ERR_LIMIT_LO;
   assign next_exceeded = (TX_ERR_COUNT_IN > limit) ||
                          (RX_ERR_COUNT_IN > limit);
   assign irq_en_all = ERROR_IRQ_ENABLE_IN && CAN_IRQ_ENABLE_IN &&
                       GLOBAL_IRQ_ENABLE_IN;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         exceeded      <= 1'b0;
         ERROR_IRQ_OUT <= 1'b0;
      end else begin
         exceeded <= next_exceeded;
         ERROR_IRQ_OUT <= irq_en_all && (exceeded != next_exceeded) &&
            (next_exceeded || ERROR_LIMIT_SELECT_IN);
      end
   end

   always_comb begin
      STATUS_OUT = 8'h00;
      STATUS_OUT[cafb_pkg::STAT_EXCEEDED_BIT] = exceeded;
   end

   // Bus timing copy on falling initialize bit
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         init_q                 <= 1'b1;
         TIMING_LOAD_OUT        <= 1'b0;
         ENGINE_TIMING_ZERO_OUT <= cafb_pkg::TIMING_RESET;
         ENGINE_TIMING_ONE_OUT  <= cafb_pkg::TIMING_RESET;
      end else begin
         init_q          <= SOFTWARE_INITIALIZE_IN;
         TIMING_LOAD_OUT <= init_q && !SOFTWARE_INITIALIZE_IN;
         if (init_q && !SOFTWARE_INITIALIZE_IN) begin
            ENGINE_TIMING_ZERO_OUT <= TIMING_ZERO_IN;
            ENGINE_TIMING_ONE_OUT  <= TIMING_ONE_IN;
         end
      end
   end

   assign BAUD_PRESCALER_OUT =
      ENGINE_TIMING_ZERO_OUT[cafb_pkg::T0_PRESC_LSB +: 6];

   // Checks
   property p_scan_done;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (state == cafb_pkg::ST_IDLE && FRAME_VALID_IN) |=>
         ##[1:16] (state == cafb_pkg::ST_IDLE);
   endproperty
   a_scan_done: assert property (p_scan_done)
      else $error("frame scan did not finish in 16 cycles");

   property p_drop_unread;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (state == cafb_pkg::ST_STORE && scan_idx != cafb_pkg::LAST_IDX &&
       DATA_UPDATED_OUT[scan_idx] && !OVERWRITE_ENABLE_IN[scan_idx])
         |-> !mem_we;
   endproperty
   a_drop_unread: assert property (p_drop_unread)
      else $error("unread center was overwritten");

   property p_overwrite;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (state == cafb_pkg::ST_STORE && scan_idx != cafb_pkg::LAST_IDX &&
       DATA_UPDATED_OUT[scan_idx] && OVERWRITE_ENABLE_IN[scan_idx])
         |-> mem_we ##1 OVERWRITE_FLAG_OUT[scan_idx];
   endproperty
   a_overwrite: assert property (p_overwrite)
      else $error("overwrite did not store or flag");

   property p_second_frame;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (state == cafb_pkg::ST_STORE && scan_idx == cafb_pkg::LAST_IDX &&
       DATA_UPDATED_OUT[14] && !buf_full) |-> !mem_we ##1 buf_full;
   endproperty
   a_second_frame: assert property (p_second_frame)
      else $error("second frame not buffered");

   property p_third_frame;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (state == cafb_pkg::ST_STORE && scan_idx == cafb_pkg::LAST_IDX &&
       DATA_UPDATED_OUT[14] && buf_full) |->
         !mem_we && (buf_we == OVERWRITE_ENABLE_IN[14]);
   endproperty
   a_third_frame: assert property (p_third_frame)
      else $error("third frame handled wrongly");

   property p_buffer_move;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (buf_full && !DATA_UPDATED_OUT[14] && !CENTER_IRQ_OUT[14] &&
       !REMOTE_REQ_OUT[14] && state != cafb_pkg::ST_STORE)
         |=> DATA_UPDATED_OUT[14] && !buf_full;
   endproperty
   a_buffer_move: assert property (p_buffer_move)
      else $error("buffered frame not moved in");

   property p_status_bit;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      next_exceeded |=> STATUS_OUT[6];
   endproperty
   a_status_bit: assert property (p_status_bit)
      else $error("exceeded flag not shown");

   property p_irq_on_clear;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      ($fell(exceeded) && $past(ERROR_LIMIT_SELECT_IN) && $past(irq_en_all))
         |-> ERROR_IRQ_OUT;
   endproperty
   a_irq_on_clear: assert property (p_irq_on_clear)
      else $error("no interrupt on flag clear");

   property p_timing_copy;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      (init_q && !SOFTWARE_INITIALIZE_IN) |=>
         TIMING_LOAD_OUT && ENGINE_TIMING_ONE_OUT == $past(TIMING_ONE_IN);
   endproperty
   a_timing_copy: assert property (p_timing_copy)
      else $error("timing not copied on initialize fall");

   property p_no_tx_last;
      @(posedge CLK_IN) disable iff (!ARST_N_IN)
      TX_LOAD_VALID_OUT |-> TX_LOAD_INDEX_OUT != cafb_pkg::LAST_IDX;
   endproperty
   a_no_tx_last: assert property (p_no_tx_last)
      else $error("center 15 picked for transmit");
endmodule : cafb_top

// [cafb_node_model.sv]
// Far-end node model: puts one error-free frame on the receive port.
// Assumes the receiver samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module cafb_node_model (
   // Clock
   input  wire logic        clk_in,
   // Frame
   output logic             valid_out,
   output logic [28:0]      id_out,
   output logic             ext_out,
   output logic [63:0]      data_out
);
   initial begin
      valid_out = 1'b0;
      id_out    = 29'h0;
      ext_out   = 1'b0;
      data_out  = 64'h0;
   end

   task send(input logic [28:0] id, input logic [63:0] d);
      @(negedge clk_in);
      valid_out <= 1'b1;
      id_out    <= id;
      data_out  <= d;
      @(negedge clk_in);
      valid_out <= 1'b0;
      // Released lines show the inverse, not a stale copy
      id_out    <= ~id;
      data_out  <= ~d;
      repeat (20) @(negedge clk_in);
   endtask : send
endmodule : cafb_node_model

// [cafb_top_tb.sv]
// Self-checking bench for the acceptance filter and buffering top.
// Assumes inputs change on the falling edge; node model feeds frames.
`timescale 1ns/1ps
module cafb_top_tb;
   logic CLK_IN = 1'b0, ARST_N_IN = 1'b0, FRAME_RTR_IN = 1'b0;
   logic FRAME_VALID_IN, FRAME_EXT_IN, TX_DONE_IN = 1'b0;
   logic TX_RELOAD_IN = 1'b0, ERROR_LIMIT_SELECT_IN = 1'b0;
   logic ERROR_IRQ_ENABLE_IN = 1'b1, CAN_IRQ_ENABLE_IN = 1'b1;
   logic GLOBAL_IRQ_ENABLE_IN = 1'b1, SOFTWARE_INITIALIZE_IN = 1'b1;
   logic [28:0] FRAME_ID_IN, EXT_MASK_IN = 29'h0, LAST_EXT_MASK_IN = 29'h0;
   logic [63:0] FRAME_DATA_IN, READ_DATA_OUT;
   logic [10:0] STD_MASK_IN = 11'h0, LAST_STD_MASK_IN = 11'h0;
   logic [15:0] MEDIA_MASK_IN = 16'h0, MEDIA_ARB_IN = 16'h0;
   logic [14:0] CENTER_ENABLED_IN = 15'h3, OVERWRITE_ENABLE_IN = 15'h0;
   logic [14:0] CLEAR_UPDATED_IN = 15'h0, CLEAR_IRQ_IN = 15'h0;
   logic [14:0] CLEAR_REMOTE_IN = 15'h0, CLEAR_OVERWRITE_IN = 15'h0;
   logic [14:0] TX_PENDING_IN = 15'h0, DATA_UPDATED_OUT, CENTER_IRQ_OUT;
   logic [14:0] REMOTE_REQ_OUT, OVERWRITE_FLAG_OUT;
   logic [434:0] CENTER_ARB_IN = {15{29'h0AB}};
   logic [119:0] CENTER_FORMAT_IN = {15{8'h80}};
   logic [3:0] READ_INDEX_IN = 4'h0, TX_DONE_INDEX_IN = 4'h0;
   logic [3:0] TX_LOAD_INDEX_OUT;
   logic [28:0] READ_ID_OUT;
   logic [7:0] TX_ERR_COUNT_IN = 8'h0, RX_ERR_COUNT_IN = 8'h0;
   logic [7:0] TIMING_ZERO_IN = 8'h0, TIMING_ONE_IN = 8'h0, STATUS_OUT;
   logic [7:0] ENGINE_TIMING_ZERO_OUT, ENGINE_TIMING_ONE_OUT;
   logic [5:0] BAUD_PRESCALER_OUT;
   logic TX_LOAD_VALID_OUT, ERROR_IRQ_OUT, TIMING_LOAD_OUT;
   int fail_count = 0, check_count = 0;

   cafb_top dut (.*);
   cafb_node_model node (.clk_in(CLK_IN), .valid_out(FRAME_VALID_IN),
      .id_out(FRAME_ID_IN), .ext_out(FRAME_EXT_IN),
      .data_out(FRAME_DATA_IN));

   initial forever #20 CLK_IN = ~CLK_IN;

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task chk(input string n, input logic [63:0] e, g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wait_hi(input string n, ref logic s);
      for (int i = 0; i < 20; i++) begin
         if (s === 1'b1) return;
         @(negedge CLK_IN);
      end
      chk(n, 1, s);
      end_of_test();
   endtask : wait_hi

   task t_hit;
      node.send(29'h0AB, 64'h0123456789ABCDEF);
      chk("upd", 15'h1, DATA_UPDATED_OUT);
      chk("irq", 15'h1, CENTER_IRQ_OUT);
      chk("data", 64'h0123456789ABCDEF, READ_DATA_OUT);
      $display("t_hit done");
   endtask : t_hit

   task t_ovw;
      node.send(29'h0AB, 64'h1111);
      chk("keep", 64'h0123456789ABCDEF, READ_DATA_OUT);
      chk("upd", 15'h1, DATA_UPDATED_OUT);
      OVERWRITE_ENABLE_IN = 15'h1;
      node.send(29'h0AB, 64'h2222);
      chk("ovw", 64'h2222, READ_DATA_OUT);
      chk("row", 15'h1, OVERWRITE_FLAG_OUT);
      $display("t_ovw done");
   endtask : t_ovw

   task t_err;
      RX_ERR_COUNT_IN = 8'h60;
      repeat (4) @(negedge CLK_IN);
      chk("stat", 8'h00, STATUS_OUT);
      RX_ERR_COUNT_IN = 8'h61;
      wait_hi("eirq", ERROR_IRQ_OUT);
      chk("stat", 8'h40, STATUS_OUT);
      @(negedge CLK_IN);
      ERROR_LIMIT_SELECT_IN = 1'b1;
      wait_hi("eclr", ERROR_IRQ_OUT);
      chk("stat", 8'h00, STATUS_OUT);
      $display("t_err done");
   endtask : t_err

   task t_tim;
      TIMING_ZERO_IN = 8'h5A;
      TIMING_ONE_IN = 8'h23;
      SOFTWARE_INITIALIZE_IN = 1'b0;
      wait_hi("load", TIMING_LOAD_OUT);
      chk("t0", 8'h5A, ENGINE_TIMING_ZERO_OUT);
      chk("t1", 8'h23, ENGINE_TIMING_ONE_OUT);
      chk("bpr", 6'h1A, BAUD_PRESCALER_OUT);
      $display("t_tim done");
   endtask : t_tim

   task t_tx;
      CENTER_ENABLED_IN = 15'h4017;
      CENTER_FORMAT_IN[19] = 1'b1;
      CENTER_FORMAT_IN[35] = 1'b1;
      CENTER_FORMAT_IN[115] = 1'b1;
      TX_PENDING_IN = 15'h4014;
      TX_RELOAD_IN = 1'b1;
      @(negedge CLK_IN);
      TX_RELOAD_IN = 1'b0;
      wait_hi("txv", TX_LOAD_VALID_OUT);
      chk("txi", 4'h2, TX_LOAD_INDEX_OUT);
      $display("t_tx done");
   endtask : t_tx

   task t_mask;
      CENTER_FORMAT_IN[0] = 1'b1;
      MEDIA_MASK_IN = 16'hFF00;
      MEDIA_ARB_IN = 16'h5500;
      node.send(29'h0AB, 64'h1234);
      chk("skip", 15'h3, DATA_UPDATED_OUT);
      node.send(29'h0AB, 64'h5599);
      chk("media", 64'h5599, READ_DATA_OUT);
      $display("t_mask done");
   endtask : t_mask

   // Software read-back of center 15: clear all three flags
   task clr15;
      CLEAR_UPDATED_IN = 15'h4000;
      CLEAR_IRQ_IN = 15'h4000;
      CLEAR_REMOTE_IN = 15'h4000;
      @(negedge CLK_IN);
      CLEAR_UPDATED_IN = 15'h0;
      CLEAR_IRQ_IN = 15'h0;
      CLEAR_REMOTE_IN = 15'h0;
      repeat (3) @(negedge CLK_IN);
   endtask : clr15

   task t_c15;
      READ_INDEX_IN = 4'hE;
      CENTER_ARB_IN[434:406] = 29'h123;
      CENTER_FORMAT_IN[113] = 1'b1;
      STD_MASK_IN = 11'h7F0;
      LAST_STD_MASK_IN = 11'h0FF;
      FRAME_RTR_IN = 1'b1;
      node.send(29'h72C, 64'hA1);
      FRAME_RTR_IN = 1'b0;
      chk("rem", 15'h4000, REMOTE_REQ_OUT);
      chk("id15", 29'h72C, READ_ID_OUT);
      node.send(29'h72C, 64'hA2);
      chk("keep15", 64'hA1, READ_DATA_OUT);
      node.send(29'h72C, 64'hA3);
      clr15();
      chk("move", 64'hA2, READ_DATA_OUT);
      chk("rem0", 15'h0, REMOTE_REQ_OUT);
      chk("upd15", 15'h4003, DATA_UPDATED_OUT);
      OVERWRITE_ENABLE_IN = 15'h4001;
      node.send(29'h72C, 64'hA4);
      node.send(29'h72C, 64'hA5);
      chk("keep2", 64'hA2, READ_DATA_OUT);
      clr15();
      chk("repl", 64'hA5, READ_DATA_OUT);
      $display("t_c15 done");
   endtask : t_c15

   initial begin
      repeat (3) @(negedge CLK_IN);
      ARST_N_IN = 1'b1;
      t_hit();
      t_ovw();
      t_err();
      t_tim();
      t_tx();
      t_mask();
      t_c15();
      end_of_test();
   end
endmodule : cafb_top_tb
